/* File: rtl/serial_consts.svh */
// named offsets, field positions, reset values and counts of the serial data path
// assumes byte addresses on a 32-bit bus, one register per aligned word
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// =====================================================================
// register byte offsets
`define OFS_DATA        8'h00
`define OFS_STATUS      8'h04
`define OFS_CONTROL     8'h08
`define OFS_FORMAT      8'h0c
`define OFS_BAUD        8'h10
`define OFS_NONE        8'hff

// =====================================================================
// status register fields
`define ST_RX_DONE      7
`define ST_TX_DONE      6
`define ST_BUF_EMPTY    5
`define ST_DOUBLE       1

// =====================================================================
// control register fields
`define CT_TXDONE_IE    6
`define CT_EMPTY_IE     5
`define CT_RX_ENABLE    4
`define CT_TX_ENABLE    3
`define CT_SIZE_TOP     2
`define CT_RX_NINTH     1
`define CT_TX_NINTH     0
`define CTRL_WMASK      8'h7d

// =====================================================================
// format register fields and reset value (eight data bits)
`define FM_SYNC         6
`define FM_PAR_EN       5
`define FM_PAR_ODD      4
`define FM_STOP2        3
`define FM_SIZE_HI      2
`define FM_SIZE_LO      1
`define FM_CLK_POL      0
`define FMT_RESET       8'h06

// =====================================================================
// character sizes and sample counts
`define SIZE_EIGHT      3'h3
`define SIZE_NINE       3'h7
`define BITS_MIN        4'h5
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9
`define OVS_NORMAL      5'h10
`define OVS_DOUBLE      5'h08

// =====================================================================
// bus encodings
`define HSIZE_WORD      3'h2
`define HTRANS_ACTIVE   1

`endif

/* File: rtl/serial_pkg.sv */
// types shared by the serial data path modules
// assumes nothing of its surroundings
package serial_pkg;

	// =================================================================
	// frame format as decoded from the control, format and status registers
	typedef struct packed {
		logic       sync;
		logic       clkPol;
		logic       parityEn;
		logic       parityOdd;
		logic       stop2;
		logic       doubleSpeed;
		logic [2:0] charSize;
	} frameCfg_t;

	// =================================================================
	// synchronised pin: level and one-cycle edge pulses
	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} pinEvent_t;

	// =================================================================
	// sequencer states
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} txState_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rxState_t;

endpackage

/* File: rtl/edge_sync.sv */
// two-flop synchroniser with edge detection for pins from outside the clock domain
// assumes pins may change at any time; lines idle high
`timescale 1ns/10ps
`default_nettype none

module edge_sync #(
	parameter int WIDTH = 2
) (
	// clock, reset and clock enable
	input  wire logic                                sys_clk,
	input  wire logic                                rst,
	input  wire logic                                ce,
	// asynchronous pins
	input  wire logic [WIDTH-1:0]                    pinIn,
	// synchronised levels and edges
	output var  serial_pkg::pinEvent_t [WIDTH-1:0]   pinEv
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] last;
	} state_t;

	state_t st_q;
	state_t st_d;

	// first stage feeds only the second; edges use stages two and three
	always_comb begin
		st_d      = st_q;
		st_d.meta = pinIn;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= '1;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// per-pin level and edge pulses
	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		assign pinEv[i].level = st_q.sync[i];
		assign pinEv[i].rise  = st_q.sync[i] & ~st_q.last[i];
		assign pinEv[i].fall  = ~st_q.sync[i] & st_q.last[i];
	end

endmodule

`default_nettype wire

/* File: rtl/baud_tick.sv */
// baud divider: one sample tick every divider+1 system clocks
// assumes divider is static while run is high
`timescale 1ns/10ps
`default_nettype none

module baud_tick #(
	parameter int DIV_W = 12
) (
	// clock, reset and clock enable
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divider,
	// one-cycle sample tick
	output logic                  tick
);

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic             tick;
	} state_t;

	state_t st_q;
	state_t st_d;

	// counter restarts whenever the divider is idle so the first tick is a full period
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (!run) begin
			st_d.count = '0;
		end else if (st_q.count == divider) begin
			st_d.count = '0;
			st_d.tick  = 1'b1;
		end else begin
			st_d.count = st_q.count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;

endmodule

`default_nettype wire

/* File: rtl/serial_tx_rx_datapath.sv */
// serial port transmit and receive data path with an AHB-Lite register slave
// assumes one 40 MHz clock, synchronous reset, word-only single transfers
`timescale 1ns/10ps
`default_nettype none
`include "serial_consts.svh"

module serial_tx_rx_datapath #(
	parameter int DIV_W = 12
) (
	// clock, reset and clock enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// ahb-lite register slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// serial line pins
	input  wire logic        rxdPin,
	input  wire logic        extClkPin,
	output logic             txdOut,
	output logic             txdOe_n,
	// general port logic that owns the pins while the port is off
	input  wire logic        portTxOut,
	input  wire logic        portTxOe_n,
	output logic             rxPinTaken,
	output logic             clkPinTaken,
	// interrupt requests towards the core
	input  wire logic        globalIrqEn,
	input  wire logic        txCompleteAck,
	output logic             bufEmptyIrq,
	output logic             txCompleteIrq
);

	// =================================================================
	// state
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [7:0]            fmt;
		logic                  dbl;
		logic [DIV_W-1:0]      baud;
		logic                  wrPend;
		logic [7:0]            wrAddr;
		logic [31:0]           rdata;
		logic [8:0]            txBuf;
		logic                  bufEmpty;
		logic                  txDone;
		logic                  txOn;
		serial_pkg::txState_t  txSt;
		logic [8:0]            txShift;
		logic [3:0]            txBitIdx;
		logic [4:0]            txSub;
		logic                  txPar;
		logic                  txLine;
		serial_pkg::rxState_t  rxSt;
		logic [8:0]            rxShift;
		logic [3:0]            rxBitIdx;
		logic [4:0]            rxSub;
		logic [8:0]            rxBuf;
		logic                  rxFull;
	} state_t;

	localparam state_t ST_RESET = '{
		fmt:      `FMT_RESET,
		bufEmpty: 1'b1,
		txLine:   1'b1,
		txSt:     serial_pkg::TX_IDLE,
		rxSt:     serial_pkg::RX_IDLE,
		default:  '0
	};

	state_t                            st_q;
	state_t                            st_d;
	serial_pkg::frameCfg_t             cfg;
	serial_pkg::pinEvent_t [1:0]       pinEv;
	logic                              ovsTick;
	logic [3:0]                        nBits;
	logic [3:0]                        lastBit;
	logic [8:0]                        charMask;
	logic [4:0]                        ovsLast;
	logic [4:0]                        ovsHalf;
	logic                              accept;
	logic [7:0]                        regAddr;
	logic                              txTick;
	logic                              txChange;
	logic                              rxSample;
	logic                              rxLvl;
	logic                              rxOn;
	logic                              loadEv;
	logic                              frameEnd;
	logic                              txDoneSet;
	logic                              rxDoneEv;

	// =================================================================
	// frame format decode
	assign cfg.sync        = st_q.fmt[`FM_SYNC];
	assign cfg.clkPol      = st_q.fmt[`FM_CLK_POL];
	assign cfg.parityEn    = st_q.fmt[`FM_PAR_EN];
	assign cfg.parityOdd   = st_q.fmt[`FM_PAR_ODD];
	assign cfg.stop2       = st_q.fmt[`FM_STOP2];
	assign cfg.doubleSpeed = st_q.dbl;
	assign cfg.charSize    = {st_q.ctrl[`CT_SIZE_TOP], st_q.fmt[`FM_SIZE_HI:`FM_SIZE_LO]};

	// reserved size codes fall back to eight bits
	always_comb begin
		nBits = `BITS_EIGHT;
		if (cfg.charSize == `SIZE_NINE) begin
			nBits = `BITS_NINE;
		end else if (cfg.charSize <= `SIZE_EIGHT) begin
			nBits = {1'b0, cfg.charSize} + `BITS_MIN;
		end
	end

	assign lastBit  = nBits - 4'h1;
	assign charMask = 9'((10'h001 << nBits) - 10'h001);
	// double speed halves the samples per bit, not the divider
	assign ovsLast  = (cfg.doubleSpeed ? `OVS_DOUBLE : `OVS_NORMAL) - 5'h01;
	assign ovsHalf  = {1'b0, ovsLast[4:1]};
	assign rxOn     = st_q.ctrl[`CT_RX_ENABLE];

	// =================================================================
	// pin synchronisers and baud divider
	edge_sync #(
		.WIDTH (2)
	) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.pinIn   ({extClkPin, rxdPin}),
		.pinEv   (pinEv)
	);

	baud_tick #(
		.DIV_W (DIV_W)
	) u_baud (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.run     (!cfg.sync && (st_q.txOn || rxOn)),
		.divider (st_q.baud),
		.tick    (ovsTick)
	);

	// synchronous bit timing
	// tx changes on one external clock edge, rx samples on the other
	assign txChange = cfg.clkPol ? pinEv[1].fall : pinEv[1].rise;
	assign txTick   = cfg.sync ? txChange : (ovsTick && st_q.txSub == ovsLast);
	assign rxSample = cfg.sync ? (cfg.clkPol ? pinEv[1].rise : pinEv[1].fall)
	                           : (ovsTick && st_q.rxSub == ovsLast);
	assign rxLvl    = pinEv[0].level;

	// bus decode: only word transfers to the low page are mapped
	assign accept  = hsel && htrans[`HTRANS_ACTIVE] && hready && hsize == `HSIZE_WORD;
	assign regAddr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : `OFS_NONE;

	// =================================================================
	// next-state logic
	always_comb begin
		st_d      = st_q;
		loadEv    = 1'b0;
		frameEnd  = 1'b0;
		txDoneSet = 1'b0;
		rxDoneEv  = 1'b0;

		if (st_q.ctrl[`CT_TX_ENABLE]) begin
			st_d.txOn = 1'b1;
		end else if (st_q.txSt == serial_pkg::TX_IDLE && st_q.bufEmpty) begin
			st_d.txOn = 1'b0;
		end

		// transmit sequencer; sub-bit counter runs only in asynchronous mode
		if (!cfg.sync && ovsTick) begin
			st_d.txSub = (st_q.txSub == ovsLast) ? 5'h00 : st_q.txSub + 5'h01;
		end
		case (st_q.txSt)
			serial_pkg::TX_IDLE: begin
				st_d.txLine = 1'b1;
				if (st_q.txOn && !st_q.bufEmpty && (!cfg.sync || txChange)) begin
					loadEv = 1'b1;
				end
			end
			serial_pkg::TX_START: begin
				if (txTick) begin
					st_d.txSt     = serial_pkg::TX_DATA;
					st_d.txBitIdx = 4'h0;
					st_d.txLine   = st_q.txShift[0];
				end
			end
			serial_pkg::TX_DATA: begin
				if (txTick && st_q.txBitIdx == lastBit) begin
					if (cfg.parityEn) begin
						st_d.txSt   = serial_pkg::TX_PARITY;
						st_d.txLine = st_q.txPar;
					end else begin
						st_d.txSt   = serial_pkg::TX_STOP1;
						st_d.txLine = 1'b1;
					end
				end else if (txTick) begin
					st_d.txBitIdx = st_q.txBitIdx + 4'h1;
					st_d.txShift  = {1'b0, st_q.txShift[8:1]};
					st_d.txLine   = st_q.txShift[1];
				end
			end
			serial_pkg::TX_PARITY: begin
				if (txTick) begin
					st_d.txSt   = serial_pkg::TX_STOP1;
					st_d.txLine = 1'b1;
				end
			end
			serial_pkg::TX_STOP1: begin
				if (txTick && cfg.stop2) begin
					st_d.txSt = serial_pkg::TX_STOP2;
				end else if (txTick) begin
					frameEnd = 1'b1;
				end
			end
			serial_pkg::TX_STOP2: begin
				frameEnd = txTick;
			end
			default: begin
				st_d.txSt = serial_pkg::TX_IDLE;
			end
		endcase

		if (frameEnd) begin
			st_d.txSt   = serial_pkg::TX_IDLE;
			st_d.txLine = 1'b1;
			loadEv      = !st_q.bufEmpty;
			txDoneSet   = st_q.bufEmpty;
		end
		if (loadEv) begin
			st_d.txShift = st_q.txBuf;
			st_d.txPar   = (^st_q.txBuf) ^ cfg.parityOdd;
			st_d.txLine  = 1'b0;
			st_d.txSt    = serial_pkg::TX_START;
			st_d.txSub   = 5'h00;
			st_d.bufEmpty = 1'b1;
		end

		// register write data phase
		if (st_q.wrPend) begin
			st_d.wrPend = 1'b0;
			case (st_q.wrAddr)
				`OFS_DATA: begin
					st_d.txBuf = {st_q.ctrl[`CT_TX_NINTH] && nBits == `BITS_NINE, hwdata[7:0]}
					             & charMask;
					st_d.bufEmpty = 1'b0;
				end
				`OFS_STATUS: begin
					// empty flag position is not writable
					st_d.dbl = hwdata[`ST_DOUBLE];
					if (hwdata[`ST_TX_DONE]) begin
						st_d.txDone = 1'b0;
					end
				end
				`OFS_CONTROL: st_d.ctrl = hwdata[7:0] & `CTRL_WMASK;
				`OFS_FORMAT:  st_d.fmt  = hwdata[7:0];
				`OFS_BAUD:    st_d.baud = hwdata[DIV_W-1:0];
				default: begin
				end
			endcase
		end

		if (txCompleteAck) begin
			st_d.txDone = 1'b0;
		end
		// completion beats a clear in the same cycle
		if (txDoneSet) begin
			st_d.txDone = 1'b1;
		end

		// address phase: reads sample state now, writes land next cycle
		if (accept && hwrite) begin
			st_d.wrPend = 1'b1;
			st_d.wrAddr = regAddr;
		end else if (accept) begin
			case (regAddr)
				// buffer already holds zeros above size
				`OFS_DATA:    st_d.rdata = {24'h000000, st_q.rxBuf[7:0]};
				`OFS_STATUS:  st_d.rdata = {24'h000000, st_q.rxFull, st_q.txDone, st_q.bufEmpty,
				                            3'h0, st_q.dbl, 1'b0};
				`OFS_CONTROL: st_d.rdata = {24'h000000, st_q.ctrl[7:2], st_q.rxBuf[8],
				                            st_q.ctrl[`CT_TX_NINTH]};
				`OFS_FORMAT:  st_d.rdata = {24'h000000, st_q.fmt};
				`OFS_BAUD:    st_d.rdata = 32'(st_q.baud);
				default:      st_d.rdata = 32'h00000000;
			endcase
			if (regAddr == `OFS_DATA) begin
				st_d.rxFull = 1'b0;
			end
		end

		// receive sequencer
		if (!cfg.sync && ovsTick) begin
			st_d.rxSub = (st_q.rxSub == ovsLast) ? 5'h00 : st_q.rxSub + 5'h01;
		end
		case (st_q.rxSt)
			serial_pkg::RX_IDLE: begin
				if (cfg.sync && rxSample && !rxLvl) begin
					st_d.rxSt     = serial_pkg::RX_DATA;
					st_d.rxBitIdx = 4'h0;
				end else if (!cfg.sync && ovsTick && !rxLvl) begin
					st_d.rxSt  = serial_pkg::RX_START;
					st_d.rxSub = 5'h00;
				end
			end
			serial_pkg::RX_START: begin
				// a start bit gone high by mid-bit was a glitch
				if (ovsTick && st_q.rxSub == ovsHalf) begin
					st_d.rxSt     = rxLvl ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
					st_d.rxSub    = 5'h00;
					st_d.rxBitIdx = 4'h0;
				end
			end
			serial_pkg::RX_DATA: begin
				if (rxSample) begin
					st_d.rxShift  = {rxLvl, st_q.rxShift[8:1]};
					st_d.rxBitIdx = st_q.rxBitIdx + 4'h1;
					if (st_q.rxBitIdx == lastBit) begin
						st_d.rxSt = cfg.parityEn ? serial_pkg::RX_PARITY : serial_pkg::RX_STOP;
					end
				end
			end
			serial_pkg::RX_PARITY: begin
				if (rxSample) begin
					st_d.rxSt = serial_pkg::RX_STOP;
				end
			end
			serial_pkg::RX_STOP: begin
				if (rxSample) begin
					rxDoneEv  = 1'b1;
					st_d.rxSt = serial_pkg::RX_IDLE;
				end
			end
			default: begin
				st_d.rxSt = serial_pkg::RX_IDLE;
			end
		endcase

		if (!rxOn) begin
			st_d.rxSt   = serial_pkg::RX_IDLE;
			st_d.rxFull = 1'b0;
		end else if (rxDoneEv) begin
			// transfer to buffer, wins over a read
			st_d.rxBuf  = 9'(st_q.rxShift >> (4'h9 - nBits));
			st_d.rxFull = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= ST_RESET;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// =================================================================
	// outputs
	// zero wait states; a frozen clock enable stretches the bus instead of losing it
	assign hreadyout   = ce;
	assign hresp       = 1'b0;
	assign hrdata      = st_q.rdata;
	assign txdOut      = st_q.txOn ? st_q.txLine : portTxOut;
	assign txdOe_n     = st_q.txOn ? 1'b0 : portTxOe_n;
	assign rxPinTaken  = rxOn;
	assign clkPinTaken = cfg.sync && (st_q.txOn || rxOn);
	assign bufEmptyIrq   = st_q.ctrl[`CT_EMPTY_IE] && st_q.bufEmpty && globalIrqEn;
	assign txCompleteIrq = st_q.ctrl[`CT_TXDONE_IE] && st_q.txDone && globalIrqEn;

	// =================================================================
	// assertions
	sequence s_data_write;
		ce && st_q.wrPend && st_q.wrAddr == `OFS_DATA;
	endsequence
	sequence s_last_stop;
		ce && frameEnd && st_q.bufEmpty && !st_q.wrPend;
	endsequence

	a_pin_owned: assert property (@(posedge sys_clk) disable iff (rst)
		ce && st_q.ctrl[`CT_TX_ENABLE] |=> !txdOe_n && txdOut == st_q.txLine)
		else $error("transmitter enabled but pin not driven by it");
	a_idle_high: assert property (@(posedge sys_clk) disable iff (rst)
		st_q.txOn && st_q.txSt == serial_pkg::TX_IDLE |-> txdOut)
		else $error("idle transmitter line not high");
	a_write_clears: assert property (@(posedge sys_clk) disable iff (rst)
		s_data_write |=> !st_q.bufEmpty)
		else $error("data write did not clear empty flag");
	a_start_low: assert property (@(posedge sys_clk) disable iff (rst)
		ce && loadEv |=> st_q.txSt == serial_pkg::TX_START && !st_q.txLine)
		else $error("loaded frame does not begin with low start bit");
	a_done_sets: assert property (@(posedge sys_clk) disable iff (rst)
		s_last_stop |=> st_q.txDone && st_q.txSt == serial_pkg::TX_IDLE)
		else $error("complete flag not set after last stop bit");
	a_done_irq: assert property (@(posedge sys_clk) disable iff (rst)
		ce && txDoneSet && st_q.ctrl[`CT_TXDONE_IE] && globalIrqEn ##1 globalIrqEn |-> txCompleteIrq)
		else $error("complete interrupt not requested");
	a_defer_off: assert property (@(posedge sys_clk) disable iff (rst)
		ce && st_q.txOn && !st_q.bufEmpty |=> st_q.txOn)
		else $error("transmitter released with pending data");
	a_rx_buffer: assert property (@(posedge sys_clk) disable iff (rst)
		ce && rxOn && rxDoneEv |=> st_q.rxFull ##0 $past(st_q.rxShift) >> (4'h9 - nBits) == st_q.rxBuf)
		else $error("received frame not moved to buffer");
	a_rx_flush: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !rxOn |=> !st_q.rxFull && st_q.rxSt == serial_pkg::RX_IDLE)
		else $error("disabled receiver kept data");

endmodule

`default_nettype wire

/* File: tb/serial_far_end.sv */
// remote serial transceiver: frames at 16 clocks a bit (divider 0)
// captures span bit samples after each start bit, stop bit included
// assumes the block's sys_clk and an idle-high line
`timescale 1ns/10ps
`default_nettype none
module serial_far_end (
	// clock
	input  wire logic  sys_clk,
	// serial line
	input  wire logic  txd,
	output logic       rxd,
	// samples taken per frame after the start bit
	input  wire logic [3:0] span,
	// captured frames
	output logic [11:0] got [4],
	output int         frames
);
	// =================================================================
	// capture: sample mid-bit so edge jitter of one clock is harmless
	// start then lsb first
	initial begin
		rxd = 1'b1;
		frames = 0;
		forever begin
			@(posedge sys_clk);
			if (txd === 1'b0) begin
				repeat (8) @(posedge sys_clk);
				got[frames] = '0;
				for (int i = 0; i < span; i++) begin
					repeat (16) @(posedge sys_clk);
					got[frames][i] = txd;
				end
				frames++;
			end
		end
	end
	// =================================================================
	// send one frame; called just after a rising edge
	// line high after stop
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (16) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/test_serial_tx_rx_datapath.sv */
// self-checking bench of the serial data path over ahb-lite
// assumes ce held high, so the slave answers with no wait states
`timescale 1ns/10ps
`default_nettype none
`include "serial_consts.svh"
module test_serial_tx_rx_datapath;
	logic sys_clk = 0, rst = 1, ce = 1, hsel = 1, hwrite = 0, extClkPin = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = `HSIZE_WORD;
	logic hreadyout, hresp, rxdPin, txdOut, txdOe_n, portTxOut = 1, portTxOe_n = 1;
	logic rxPinTaken, clkPinTaken, globalIrqEn = 1, txCompleteAck = 0;
	logic bufEmptyIrq, txCompleteIrq;
	logic [11:0] got [4];
	logic [3:0] span = 4'h9;
	int frames, fail_count = 0, total_checks = 0, n;
	always #12.5 sys_clk = ~sys_clk;
	serial_tx_rx_datapath serial_tx_rx_datapath_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rxdPin(rxdPin), .extClkPin(extClkPin), .txdOut(txdOut),
		.txdOe_n(txdOe_n), .portTxOut(portTxOut), .portTxOe_n(portTxOe_n),
		.rxPinTaken(rxPinTaken), .clkPinTaken(clkPinTaken), .globalIrqEn(globalIrqEn),
		.txCompleteAck(txCompleteAck), .bufEmptyIrq(bufEmptyIrq),
		.txCompleteIrq(txCompleteIrq));
	serial_far_end serial_far_end_inst (.sys_clk(sys_clk), .txd(txdOut), .rxd(rxdPin),
		.got(got), .frames(frames), .span(span));
	// =================================================================
	// verdict and comparison helpers
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// a used-up bound counts as a mismatch and ends the run
	task limit(input int lim);
		if (n >= lim) begin
			fail_count++;
			test_done;
		end
	endtask
	// one single word transfer; waits on hready in both phases
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		for (n = 0; n < 1 || (n < 20 && hreadyout !== 1'b1); n++) @(posedge sys_clk);
		limit(20);
		htrans <= 2'h0;
		hwdata <= d;
		for (n = 0; n < 1 || (n < 20 && hreadyout !== 1'b1); n++) @(posedge sys_clk);
		limit(20);
		r = hrdata;
	endtask
	// =================================================================
	// wait helpers; every wait is bounded and a used-up bound fails the run
	task waitFrames(input int f);
		for (n = 0; n < 600 && frames < f; n++) @(posedge sys_clk);
		limit(600);
	endtask
	task waitTxDone;
		for (n = 0; n < 50 && txCompleteIrq !== 1'b1; n++) @(posedge sys_clk);
		limit(50);
	endtask
	// polls the receive flag; r keeps the last status read
	task waitRx;
		int k;
		for (k = 0; k < 100; k++) begin
			bus(0, `OFS_STATUS, 0);
			if (r[`ST_RX_DONE] === 1'b1) break;
		end
		n = k;
		limit(100);
	endtask
	// =================================================================
	// scenarios; captured frames carry the stop bit as their top sample
	task resetValues;
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h20);
		bus(0, `OFS_FORMAT, 0);
		chk(r, 32'h06);
		bus(0, 32'h80, 0);
		chk(r, 32'h0);
		chk(txdOe_n, portTxOe_n);
	endtask
	// the enable lands with the write and reaches the pin one edge later
	task txBackToBack;
		bus(1, `OFS_CONTROL, 32'h78);
		repeat (2) @(negedge sys_clk);
		chk(txdOe_n, 1'b0);
		chk(txdOut, 1'b1);
		chk(bufEmptyIrq, 1'b1);
		bus(1, `OFS_DATA, 32'ha5);
		bus(1, `OFS_DATA, 32'h3c);
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h00);
		chk(bufEmptyIrq, 1'b0);
		waitFrames(2);
		waitTxDone;
		chk(got[0], 12'h1a5);
		chk(got[1], 12'h13c);
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h60);
		txCompleteAck <= 1'b1;
		@(posedge sys_clk);
		txCompleteAck <= 1'b0;
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h20);
	endtask
	task rxFrame;
		@(posedge sys_clk);
		serial_far_end_inst.send(8'h96);
		waitRx;
		chk(r, 32'ha0);
		bus(0, `OFS_DATA, 0);
		chk(r, 32'h96);
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h20);
	endtask
	// seven bits, even parity: the dropped top bit must not reach the parity
	task shortChar;
		bus(1, `OFS_FORMAT, 32'h24);
		serial_far_end_inst.send(8'h96);
		waitRx;
		bus(0, `OFS_DATA, 0);
		chk(r, 32'h16);
		bus(1, `OFS_DATA, 32'hff);
		waitFrames(3);
		waitTxDone;
		chk(got[2], 12'h1ff);
		bus(1, `OFS_STATUS, 32'h40);
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h20);
	endtask
	// nine bits, odd parity: ninth bit goes to control before the low byte
	task txNineBit;
		span <= 4'hb;
		bus(1, `OFS_FORMAT, 32'h36);
		bus(1, `OFS_CONTROL, 32'h7d);
		bus(1, `OFS_DATA, 32'h0000ffa5);
		waitFrames(4);
		waitTxDone;
		chk(got[3], 12'h5a5);
		bus(0, `OFS_STATUS, 0);
		chk(r, 32'h60);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		resetValues;
		txBackToBack;
		rxFrame;
		shortChar;
		txNineBit;
		test_done;
	end
endmodule
`default_nettype wire
